/* File: rtl/pixlink_pkg.sv */
// shared constants for the pixel serial link transmitter
package pixlink_pkg;
   // ******************************************************
   // register map (offsets chosen locally)
   // ******************************************************
   localparam logic [3:0] REG_CTRL_OFF   = 4'h0; // mode, dither, lut, soft reset
   localparam logic [3:0] REG_STATUS_OFF = 4'h4; // sleep and fifo state
   localparam logic [3:0] REG_LUT_OFF    = 4'h8; // lut write: idx, value
   // ctrl field positions
   localparam int CTRL_WIDE_BIT   = 0;
   localparam int CTRL_DITHER_BIT = 1;
   localparam int CTRL_LUT_BIT    = 2;
   localparam int CTRL_SRST_BIT   = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0; // dither and lut off, 18-bit
   // ******************************************************
   // timing
   // ******************************************************
   localparam int MCLK_PERIOD_NS   = 8;
   localparam int PCLK_STOP_CYC    = 4;   // least stop gap, pixel periods
   localparam int PCLK_MAX_PER_NS  = 200; // slowest pixel clock served
   // stop detect: a gap longer than one slow pixel period at mclk rate
   localparam int STOP_DET_CYC = (PCLK_MAX_PER_NS + MCLK_PERIOD_NS - 1)
                                 / MCLK_PERIOD_NS;
   localparam int MULT_NARROW = 6; // serial clocks per pixel, 18-bit
   localparam int MULT_WIDE   = 8; // serial clocks per pixel, 24-bit
   localparam int FIFO_DEPTH  = 16;
   localparam int PIX_W       = 27; // 24 colour + hsync, vsync, enable
   localparam int SYNC_BITS   = 3;

   // sleep states
   typedef enum logic [1:0] {
      ST_AWAKE   = 2'b00,
      ST_PD      = 2'b01,
      ST_CLKSTOP = 2'b10
   } pwr_t;
endpackage

/* File: rtl/pix_fifo.sv */
// synchronous fifo for captured pixel words
`timescale 1ns/1ps
`default_nettype none
module pix_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   // pointer wrap logic serves power-of-two depths only
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("depth must be pow2");
   end
   logic [WIDTH-1:0] mem [DEPTH];           // storage array
   logic [AW:0]      wp_r;                  // write pointer
   logic [AW:0]      rp_r;                  // read pointer
   logic             full;
   logic             empty;
   assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty     = (wp_r == rp_r);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rp_r[AW-1:0]];
   // ******************************************************
   // pointers and storage
   // ******************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (flush) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && !full) wp_r <= wp_r + 1'b1;
         if (out_ready && !empty) rp_r <= rp_r + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (in_valid && !full) mem[wp_r[AW-1:0]] <= in_data;
   end
endmodule // pix_fifo
`default_nettype wire

/* File: rtl/pixlink_tx.sv */
// pixel bus capture, serial link transmit and sleep control
`timescale 1ns/1ps
`default_nettype none
// What this block, the far end and the host do
// RULE_01 - capture pixels on pixel clock rising edge
// RULE_02 - data lanes change on both clock edges
// RULE_03 - 18-bit mode: serial clock six times pixel
// RULE_04 - 24-bit mode: serial clock eight times pixel
// RULE_05 - one clock lane, two data lanes
// RULE_06 - dither and lut off after reset
// RULE_07 - power-down low forces sleep
// RULE_08 - stopped pixel clock also forces sleep
// RULE_09 - clock-stop sleep keeps settings and lut
// RULE_10 - far end checks parity, flags errors (the model checks 24-bit frames only)
// RULE_11 - far end width follows its select
// RULE_12 - power-down sleep resets settings, keeps lut
// RULE_13 - host holds clock still four periods
// RULE_14 - clock restart resumes with kept settings
// RULE_15 - host waits for wake before pixels
module pixlink_tx #(
   parameter int DEPTH = pixlink_pkg::FIFO_DEPTH
) (
   input  wire logic        MCLK,
   input  wire logic        RESETN,
   input  wire logic        PIXEL_CLK,
   input  wire logic [23:0] PIXEL_RGB,
   input  wire logic        PIXEL_HS,
   input  wire logic        PIXEL_VS,
   input  wire logic        PIXEL_DE,
   input  wire logic        POWER_DOWN_N,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   output logic             SERIAL_CLOCK_LANE,
   output logic      [1:0]  SERIAL_DATA_LANE,
   output logic             SLEEP,
   output logic             LINK_READY
);
   // refuse a fifo too shallow to decouple capture from sending
   if (DEPTH < 2) begin : g_bad_depth
      $error("fifo depth too small");
   end
   localparam int PW = pixlink_pkg::PIX_W;
   localparam int SW = $clog2(pixlink_pkg::STOP_DET_CYC + 1);
   // ******************************************************
   // state record
   // ******************************************************
   typedef struct packed {
      logic [2:0]    pclk_s;    // pixel clock sync + edge history
      logic [29:0]   pin_s1;    // pixel pins first stage
      logic [29:0]   pin_s2;    // pixel pins second stage
      logic [SW-1:0] stop_cnt;  // cycles since last pixel edge
      pixlink_pkg::pwr_t pwr;   // sleep state
      logic [3:0]    ctrl;      // software control bits
      logic [PW+2:0] shreg;     // shift word: parity + pixel, padded
      logic [4:0]    bitn;      // half-bits remaining per lane
      logic          sclk;      // forwarded serial clock level
      logic [1:0]    lanes;     // data lane levels
      logic [31:0]   rdata;     // read data
      logic [7:0]    lut_idx;   // lut write index
   } st_t;
   st_t s_r;
   st_t s_nxt;
   logic [23:0] lut [256];      // colour correction table, survives sleep
   logic        pix_edge;
   logic        fifo_in_ready;
   logic [PW-1:0] fifo_out;
   logic        fifo_out_valid;
   logic        fifo_pop;
   logic        awake;
   logic [PW-1:0] cap_word;
   logic        lut_wr;
   logic [23:0] rgb_corr;
   logic [23:0] rgb_out;
   assign pix_edge = s_r.pclk_s[1] && !s_r.pclk_s[2];
   assign awake    = (s_r.pwr == pixlink_pkg::ST_AWAKE);
   assign lut_wr   = REG_WR && (REG_ADDR == pixlink_pkg::REG_LUT_OFF);
   // ******************************************************
   // colour correction and dither on the captured colour
   // ******************************************************
   always_comb begin
      rgb_corr = s_r.ctrl[pixlink_pkg::CTRL_LUT_BIT] ?
                 lut[s_r.pin_s2[7:0]] : s_r.pin_s2[23:0];
      // simple ordered dither: add half lsb of 6-bit colour, FE and FF left unchanged
      rgb_out = rgb_corr;
      if (s_r.ctrl[pixlink_pkg::CTRL_DITHER_BIT]) begin
         for (int c = 0; c < 3; c++) begin
            if (rgb_corr[c*8 +: 8] < 8'hFE)
               rgb_out[c*8 +: 8] = rgb_corr[c*8 +: 8] + 8'h02;
         end
      end
   end
   assign cap_word = {s_r.pin_s2[26:24], rgb_out};
   // ******************************************************
   // capture fifo
   // ******************************************************
   pix_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo (
      .clk       (MCLK),
      .rst_n     (RESETN),
      .flush     (!awake),
      .in_data   (cap_word),
      .in_valid  (pix_edge && awake),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop)
   );
   assign fifo_pop = awake && (s_r.bitn == 5'h00) && fifo_out_valid;
   // ******************************************************
   // next state
   // ******************************************************
   always_comb begin
      logic       wide;
      logic [4:0] halves;
      s_nxt = s_r;
      wide  = s_r.ctrl[pixlink_pkg::CTRL_WIDE_BIT];
      // RULE_03 RULE_04 six or eight serial clocks per pixel
      halves = wide ? 5'(2 * pixlink_pkg::MULT_WIDE)
                    : 5'(2 * pixlink_pkg::MULT_NARROW);
      // pixel clock is sampled as a plain pin
      s_nxt.pclk_s = {s_r.pclk_s[1:0], PIXEL_CLK};
      // RULE_01 capture on rising edge
      s_nxt.pin_s1 = {POWER_DOWN_N, 2'b00, PIXEL_DE, PIXEL_VS, PIXEL_HS,
                      PIXEL_RGB};
      s_nxt.pin_s2 = s_r.pin_s1;
      // RULE_08 stop detect counter
      if (pix_edge)
         s_nxt.stop_cnt = '0;
      else if (s_r.stop_cnt != SW'(pixlink_pkg::STOP_DET_CYC))
         s_nxt.stop_cnt = s_r.stop_cnt + 1'b1;
      // RULE_07 power-down pin has priority
      if (!s_r.pin_s2[29]) begin
         s_nxt.pwr = pixlink_pkg::ST_PD;
         // RULE_12 settings back to defaults
         s_nxt.ctrl = pixlink_pkg::CTRL_RESET;
      end else if (pix_edge) begin
         // RULE_14 resume with retained settings
         // first edge after a stop must wake, so it beats the stop count
         s_nxt.pwr = pixlink_pkg::ST_AWAKE;
      end else if (s_r.stop_cnt == SW'(pixlink_pkg::STOP_DET_CYC)) begin
         // RULE_09 clock-stop sleep keeps ctrl
         s_nxt.pwr = pixlink_pkg::ST_CLKSTOP;
      end
      // soft reset bit returns settings to defaults
      if (s_r.ctrl[pixlink_pkg::CTRL_SRST_BIT])
         s_nxt.ctrl = pixlink_pkg::CTRL_RESET;
      // RULE_06 enables only via software write
      if (REG_WR && REG_ADDR == pixlink_pkg::REG_CTRL_OFF && s_r.pin_s2[29])
         s_nxt.ctrl = REG_WDATA[3:0];
      if (lut_wr)
         s_nxt.lut_idx = REG_WDATA[31:24];
      // register reads, data one cycle later
      s_nxt.rdata = 32'h0000_0000;
      if (REG_RD) begin
         unique case (REG_ADDR)
            pixlink_pkg::REG_CTRL_OFF:   s_nxt.rdata = {28'h0, s_r.ctrl};
            pixlink_pkg::REG_STATUS_OFF:
               s_nxt.rdata = {28'h0, fifo_out_valid, !fifo_in_ready,
                              s_r.pwr};
            default:                     s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // serializer: one half-bit per mclk, sclk toggles each half
      if (!awake) begin
         s_nxt.bitn  = 5'h00;
         s_nxt.sclk  = 1'b0;
         s_nxt.lanes = 2'b00;
      end else if (fifo_pop) begin
         // odd parity over the pixel word sits above it, sent after it (padding follows) and only in a wide frame
         s_nxt.shreg = {2'b00, ~^fifo_out, fifo_out};
         s_nxt.bitn  = halves;
         s_nxt.sclk  = 1'b0;
      end else if (s_r.bitn != 5'h00) begin
         // RULE_02 new bits on every clock edge
         s_nxt.sclk  = ~s_r.sclk;
         // RULE_05 two lanes carry bits in parallel
         s_nxt.lanes = s_r.shreg[1:0];
         s_nxt.shreg = {2'b00, s_r.shreg[PW+2:2]};
         s_nxt.bitn  = s_r.bitn - 1'b1;
      end
   end
   // ******************************************************
   // state register
   // ******************************************************
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         s_r      <= '0;
         s_r.pwr  <= pixlink_pkg::ST_PD;
         s_r.ctrl <= pixlink_pkg::CTRL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end
   // lut storage, never cleared by sleep
   always_ff @(posedge MCLK) begin
      if (lut_wr) lut[REG_WDATA[31:24]] <= REG_WDATA[23:0];
   end
   assign REG_RDATA         = s_r.rdata;
   assign SERIAL_CLOCK_LANE = s_r.sclk;
   assign SERIAL_DATA_LANE  = s_r.lanes;
   assign SLEEP             = !awake;
   assign LINK_READY        = awake && fifo_in_ready;
endmodule // pixlink_tx
`default_nettype wire

/* File: tb/pixlink_tx_checker.sv */
// port assertions for the pixel link transmitter
`timescale 1ns/1ps
`default_nettype none
module pixlink_tx_checker #(parameter int DEPTH = 16) (
   input wire logic        MCLK,
   input wire logic        RESETN,
   input wire logic        PIXEL_CLK,
   input wire logic        POWER_DOWN_N,
   input wire logic [3:0]  REG_ADDR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        SERIAL_CLOCK_LANE,
   input wire logic [1:0]  SERIAL_DATA_LANE,
   input wire logic        SLEEP
);
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);
   logic [5:0] still_r; // cycles with pixel clock unchanged
   logic       pclk_q;  // pixel clock, last sample
   // count how long the pixel clock stands still
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         still_r <= 6'h00;
         pclk_q  <= 1'b0;
      end else begin
         pclk_q  <= PIXEL_CLK;
         still_r <= (PIXEL_CLK != pclk_q) ? 6'h00 :
                    (still_r == 6'h3F) ? still_r : still_r + 6'h01;
      end
   end
   sequence s_pd_held;
      !POWER_DOWN_N [*4];
   endsequence
   sequence s_half;
      $rose(SERIAL_CLOCK_LANE) ##1 $fell(SERIAL_CLOCK_LANE);
   endsequence
   a_pd_sleep: assert property (s_pd_held |-> ##[0:2] SLEEP)
      else $error("sleep missing under power-down");
   a_pd_ctrl: assert property (s_pd_held ##0 (REG_RD && REG_ADDR == 4'h0)
      |=> REG_RDATA[3:0] == 4'h0) else $error("ctrl kept under power-down");
   a_stop_sleep: assert property (still_r == 6'h28 |-> SLEEP)
      else $error("no sleep on stopped pixel clock");
   a_pclk_wake: assert property ($rose(PIXEL_CLK) && POWER_DOWN_N
      && $past(POWER_DOWN_N, 4) |-> ##[0:8] !SLEEP) else $error("no wake");
   a_sleep_quiet: assert property (SLEEP [*3] |=>
      $stable(SERIAL_CLOCK_LANE)) else $error("serial clock runs asleep");
   a_data_edge: assert property ($changed(SERIAL_DATA_LANE) && !SLEEP
      |-> $changed(SERIAL_CLOCK_LANE)) else $error("data off clock edge");
   a_half_rate: assert property ($rose(SERIAL_CLOCK_LANE) |-> s_half)
      else $error("serial clock high half too long");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data outside read slot");
endmodule // pixlink_tx_checker
bind pixlink_tx pixlink_tx_checker #(.DEPTH(DEPTH)) i_chk (.MCLK(MCLK),
   .RESETN(RESETN), .PIXEL_CLK(PIXEL_CLK), .POWER_DOWN_N(POWER_DOWN_N),
   .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .SERIAL_CLOCK_LANE(SERIAL_CLOCK_LANE),
   .SERIAL_DATA_LANE(SERIAL_DATA_LANE), .SLEEP(SLEEP));
`default_nettype wire

/* File: tb/link_rx_model.sv */
// behavioural display-side receiver of the serial link
`timescale 1ns/1ps
`default_nettype none
module link_rx_model (
   input  wire logic        clk,
   input  wire logic        wide_colour_select,
   input  wire logic        serial_clock_lane,
   input  wire logic [1:0]  serial_data_lane,
   output logic      [31:0] word_r,
   output logic      [3:0]  rises_r,
   output int               frames_r,
   output logic             parity_error_flag
);
   logic        sc_q = 1'b0; // clock lane, last sample
   logic [31:0] sh_r;        // bits gathered, lsb first
   logic [31:0] nxt;         // gathered bits with this edge
   logic [3:0]  nr_r = 4'h0; // clock rises in this frame
   int          nb_r = 0;    // bits gathered in this frame
   int          idle_r = 0;  // cycles since the last clock lane edge
   initial frames_r = 0;
   // two bits taken at every clock lane edge, rise and fall
   always @(posedge clk) begin
      nxt = {serial_data_lane, sh_r[31:2]};
      sc_q <= serial_clock_lane;
      if (serial_clock_lane != sc_q) begin
         sh_r <= nxt;
         if (serial_clock_lane) nr_r <= nr_r + 4'h1;
         nb_r <= nb_r + 2;
         idle_r <= 0;
         // frame length follows width select
         // a frame ends on a falling edge, so its rises are all counted
         if (nb_r + 2 == (wide_colour_select ? 32 : 24)) begin
            word_r <= wide_colour_select ? nxt : nxt >> 8;
            rises_r <= nr_r;
            frames_r <= frames_r + 1;
            // odd parity over the low 28 bits of a wide frame
            parity_error_flag <= wide_colour_select && !(^nxt[27:0]);
            nb_r <= 0;
            nr_r <= 4'h0;
         end
      end else if (idle_r > 2) begin
         nb_r <= 0;
         nr_r <= 4'h0;
      end else idle_r <= idle_r + 1;
   end
endmodule // link_rx_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the pixel link transmitter
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic MCLK, RESETN, PIXEL_CLK, PIXEL_HS, PIXEL_VS, PIXEL_DE, POWER_DOWN_N;
   logic REG_WR, REG_RD, SERIAL_CLOCK_LANE, SLEEP, LINK_READY, wide, run, perr;
   logic [23:0] PIXEL_RGB;
   logic [3:0] REG_ADDR, rises;
   logic [31:0] REG_WDATA, REG_RDATA, word;
   logic [1:0] SERIAL_DATA_LANE;
   int errors = 0, checked = 0, frames;
   pixlink_tx #(.DEPTH(16)) i_dut (.MCLK(MCLK), .RESETN(RESETN),
      .PIXEL_CLK(PIXEL_CLK), .PIXEL_RGB(PIXEL_RGB), .PIXEL_HS(PIXEL_HS),
      .PIXEL_VS(PIXEL_VS), .PIXEL_DE(PIXEL_DE), .POWER_DOWN_N(POWER_DOWN_N),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP(SLEEP),
      .SERIAL_CLOCK_LANE(SERIAL_CLOCK_LANE), .LINK_READY(LINK_READY),
      .SERIAL_DATA_LANE(SERIAL_DATA_LANE));
   link_rx_model i_rx (.clk(MCLK), .wide_colour_select(wide),
      .serial_clock_lane(SERIAL_CLOCK_LANE), .word_r(word), .rises_r(rises),
      .serial_data_lane(SERIAL_DATA_LANE), .frames_r(frames),
      .parity_error_flag(perr));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   // pixel clock, unrelated in phase, static while run is low
   initial begin
      PIXEL_CLK = 1'b0;
      #3;
      forever #40 if (run) PIXEL_CLK = ~PIXEL_CLK;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge MCLK);
      {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, exp);
      @(posedge MCLK);
      {REG_ADDR, REG_RD} <= {a, 1'b1};
      @(posedge MCLK);
      REG_RD <= 1'b0;
      #1;
      chk("rdata", REG_RDATA & m, exp);
   endtask
   task automatic wait_sleep(input logic v);
      for (int n = 0; n < 400 && SLEEP !== v; n++) @(posedge MCLK);
      chk("sleep", 32'(SLEEP), 32'(v));
   endtask
   task automatic wait_frames(input logic [3:0] exp_r);
      int f0 = frames;
      for (int n = 0; n < 400 && frames < f0 + 2; n++) @(posedge MCLK);
      chk("rises", 32'(rises), 32'(exp_r));
      if (wide) chk("word", {5'h0, word[26:0]},
         {5'h0, PIXEL_DE, PIXEL_VS, PIXEL_HS, PIXEL_RGB});
      chk("parity", 32'(perr), 32'h0);
   endtask
   task automatic t_wide;
      rd(4'h0, 32'hF, 32'h0);
      rd(4'hC, 32'hFFFFFFFF, 32'h0);
      wr(4'h0, 32'h1);
      rd(4'h0, 32'hF, 32'h1);
      run = 1'b1;
      wait_sleep(1'b0);
      wait_frames(4'h8);
      for (int n = 0; n < 2000 && LINK_READY !== 1'b0; n++) @(posedge MCLK);
      chk("ready", 32'(LINK_READY), 32'h0);
   endtask
   task automatic t_stop;
      run = 1'b0;
      wait_sleep(1'b1);
      rd(4'h4, 32'h3, 32'h2);
      rd(4'h0, 32'hF, 32'h1);
      // hold still well past four pixel periods
      repeat (40) @(posedge MCLK);
      run = 1'b1;
      wait_sleep(1'b0);
      wait_frames(4'h8);
   endtask
   task automatic t_pd;
      POWER_DOWN_N <= 1'b0;
      wait_sleep(1'b1);
      rd(4'h4, 32'h3, 32'h1);
      rd(4'h0, 32'hF, 32'h0);
      wr(4'h0, 32'h1);
      rd(4'h0, 32'hF, 32'h0);
      wide = 1'b0;
      POWER_DOWN_N <= 1'b1;
      wait_sleep(1'b0);
      wait_frames(4'h6);
   endtask
   initial begin
      {RESETN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, run} = '0;
      {POWER_DOWN_N, wide, PIXEL_DE, PIXEL_VS, PIXEL_HS} = 5'h1B;
      PIXEL_RGB = 24'hA5C31E;
      repeat (8) @(posedge MCLK);
      RESETN <= 1'b1;
      t_wide;
      t_stop;
      t_pd;
      end_sim;
   end
   initial begin
      #200000;
      errors++;
      end_sim;
   end
endmodule // tb
`default_nettype wire
